//--- verilog/cpu_status_pkg.sv
// constants for the processor status word, system registers and register file
// assumes a single core clock and an axi4-lite master with 32-bit data
// Function
// (RULE_01) the status word is split in two halves, the upper half 31..16 holding mode and state.
// (RULE_02) carry, zero, negative, overflow, saturation, lock and scratch sit in the lower half 15..0.
// (RULE_03) the upper half may be read or written only in a privileged mode, never from application mode.
// (RULE_04) bit 31 is the secure flag and reads one exactly while the core runs in secure state.
// (RULE_05) before architecture revision 3 the secure flag is held at zero.
// (RULE_06) the secure flag reset value is chosen by the implementation through a parameter.
// (RULE_07) on revision 3 the no_compare_auto_clear bit stops the counter clearing on compare match.
// (RULE_08) the first configuration register reports the architecture revision read-only.
// (RULE_09) the secure-state registers exist only on a revision 3 implementation.
// (RULE_10) reset clears exec mode bits 2 and 1 and sets bit 0, giving supervisor mode.
// (RULE_11) while the global interrupt mask is set every interrupt level is blocked.
// (RULE_12) a register file of sixteen 32-bit registers is provided.
// (RULE_13) reserved status bits read as zero and ignore writes.
package cpu_status_pkg;
    localparam logic [11:0] STATUS_OFS      = 12'h000;
    localparam logic [11:0] CPU_CTRL_OFS    = 12'h00c;
    localparam logic [11:0] FIRST_CONFIG_REG_OFS     = 12'h100;
    localparam logic [11:0] COUNT_OFS       = 12'h108;
    localparam logic [11:0] COMPARE_OFS     = 12'h10c;
    localparam logic [11:0] SECURE_STAT_OFS = 12'h180;
    localparam logic [11:0] REGFILE_OFS     = 12'h040;
    localparam int          REGFILE_DEPTH   = 16;

    // status word field positions
    localparam int SECURE_BIT = 31;
    localparam int DBG_MASK_BIT = 27;
    localparam int DBG_STATE_BIT = 26;
    localparam int MODE_LSB   = 22;
    localparam int EXC_MASK_BIT = 21;
    localparam int LVL_MASK_LSB = 17;
    localparam int GLOBAL_MASK_BIT = 16;
    localparam logic [31:0] STATUS_WR_MASK = 32'h8dff_403f;
    localparam logic [31:0] STATUS_RESET   = 32'h0061_0000;
    localparam logic [2:0]  MODE_APP       = 3'h0;

    localparam int NO_AUTO_CLEAR_BIT = 0;
    localparam int REV_LSB = 10;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

//--- verilog/cpu_status_regs.sv
// status word, control, configuration, counter and register file of the core
// assumes an axi4-lite master on ref_clk_i; irq requests come from logic on the same clock
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module cpu_status_regs import cpu_status_pkg::*; #(
    parameter logic [2:0] ARCH_REV     = 3'h3,
    parameter logic       SECURE_RESET = 1'b0
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    // axi4-lite write
    input  wire logic [11:0] s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    // axi4-lite read
    input  wire logic [11:0] s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // core side
    input  wire logic [3:0]  irq_req_i,
    output logic [3:0]       irq_enabled_o,
    output logic [31:0]      status_word_o,
    output logic             compare_match_o
);
    typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_e;

    localparam logic IS_REV3 = (ARCH_REV >= 3'h3);

    logic [31:0] status_q, cpu_ctrl_q, count_q, compare_q, secure_stat_q;
    logic [31:0] regs_q [REGFILE_DEPTH];
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        aw_got_q, w_got_q;
    wr_state_e   wr_state_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [3:0]  irq_en_q;
    logic        match_q;

    // which byte lanes the current mode may reach in the status word
    function automatic logic [3:0] lane_allow(input logic [31:0] st);
        lane_allow = (st[MODE_LSB +: 3] == MODE_APP) ? 4'h3 : 4'hf;
    endfunction

    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == STATUS_OFS) || (a == CPU_CTRL_OFS) || (a == FIRST_CONFIG_REG_OFS) ||
                      (a == COUNT_OFS) || (a == COMPARE_OFS) ||
                      (IS_REV3 && a == SECURE_STAT_OFS) ||
                      (a[11:6] == REGFILE_OFS[11:6] && a[1:0] == 2'h0);
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            strb_merge[8*i +: 8] = s[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    logic        do_write;
    logic        status_wr, ctrl_wr, count_wr, compare_wr, secure_wr, regs_wr;
    logic        upper_refused;
    logic [31:0] status_wmask, status_merged;
    assign do_write      = aw_got_q && w_got_q && wr_state_q == WR_IDLE;
    assign status_wr     = do_write && awaddr_q == STATUS_OFS;
    assign ctrl_wr       = do_write && awaddr_q == CPU_CTRL_OFS;
    assign count_wr      = do_write && awaddr_q == COUNT_OFS;
    assign compare_wr    = do_write && awaddr_q == COMPARE_OFS;
    assign secure_wr     = do_write && IS_REV3 && awaddr_q == SECURE_STAT_OFS; // RULE_09
    assign regs_wr       = do_write && awaddr_q[11:6] == REGFILE_OFS[11:6] && awaddr_q[1:0] == 2'h0;
    assign upper_refused = |(wstrb_q & ~lane_allow(status_q)); // RULE_03
    // reserved bits and, before revision 3, the secure flag never take a write
    assign status_wmask  = STATUS_WR_MASK & ~(IS_REV3 ? 32'h0 : 32'h8000_0000); // RULE_13 RULE_05
    assign status_merged = strb_merge(status_q, wdata_q, wstrb_q & lane_allow(status_q)); // RULE_03

    // write channel: address and data taken in either order, response after both
    assign s_axi_awready_o = !aw_got_q && wr_state_q == WR_IDLE;
    assign s_axi_wready_o  = !w_got_q && wr_state_q == WR_IDLE;
    assign s_axi_bvalid_o  = wr_state_q == WR_RESP;
    assign s_axi_bresp_o   = bresp_q;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            aw_got_q   <= 1'b0;
            w_got_q    <= 1'b0;
            awaddr_q   <= 12'h000;
            wdata_q    <= 32'h0000_0000;
            wstrb_q    <= 4'h0;
            wr_state_q <= WR_IDLE;
            bresp_q    <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata_i;
                wstrb_q <= s_axi_wstrb_i;
            end
            case (wr_state_q)
                WR_IDLE: begin
                    if (do_write) begin
                        aw_got_q   <= 1'b0;
                        w_got_q    <= 1'b0;
                        wr_state_q <= WR_RESP;
                        if (!addr_mapped(awaddr_q))
                            bresp_q <= RESP_DECERR;
                        else if (awaddr_q == STATUS_OFS && upper_refused)
                            bresp_q <= RESP_SLVERR;
                        else
                            bresp_q <= RESP_OKAY;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready_i)
                        wr_state_q <= WR_IDLE;
                end
                default: wr_state_q <= WR_IDLE;
            endcase
        end
    end

    // status word; mode bits come up as supervisor
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            status_q <= STATUS_RESET | ({31'h0, SECURE_RESET && IS_REV3} << SECURE_BIT); // RULE_04 RULE_06 RULE_10
        end else if (status_wr) begin
            status_q <= (status_merged & status_wmask) | (status_q & ~status_wmask); // RULE_01 RULE_02
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i)
            cpu_ctrl_q <= 32'h0000_0000;
        else if (ctrl_wr && wstrb_q[0])
            cpu_ctrl_q <= {31'h0, wdata_q[NO_AUTO_CLEAR_BIT] & IS_REV3}; // RULE_07
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i)
            secure_stat_q <= 32'h0000_0000;
        else if (secure_wr)
            secure_stat_q <= strb_merge(secure_stat_q, wdata_q, wstrb_q);
    end

    // cycle counter; clearing on match is optional from revision 3
    logic cmp_hit;
    assign cmp_hit = count_q == compare_q && compare_q != 32'h0;
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            count_q   <= 32'h0000_0000;
            compare_q <= 32'h0000_0000;
            match_q   <= 1'b0;
        end else begin
            match_q <= cmp_hit;
            if (count_wr)
                count_q <= strb_merge(count_q, wdata_q, wstrb_q);
            else if (cmp_hit && !cpu_ctrl_q[NO_AUTO_CLEAR_BIT])
                count_q <= 32'h0000_0000; // RULE_07
            else
                count_q <= count_q + 32'h1;
            if (compare_wr)
                compare_q <= strb_merge(compare_q, wdata_q, wstrb_q);
        end
    end

    // general register file
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < REGFILE_DEPTH; i++)
                regs_q[i] <= 32'h0000_0000;
        end else if (regs_wr) begin
            regs_q[awaddr_q[5:2]] <= strb_merge(regs_q[awaddr_q[5:2]], wdata_q, wstrb_q); // RULE_12
        end
    end

    // read channel: one cycle from address to data
    logic [31:0] rd_val;
    logic [1:0]  rd_resp;
    always_comb begin
        rd_val  = 32'h0000_0000;
        rd_resp = RESP_OKAY;
        if (!addr_mapped(s_axi_araddr_i)) begin
            rd_resp = RESP_DECERR; // RULE_09
        end else if (s_axi_araddr_i == STATUS_OFS) begin
            rd_val = status_q & STATUS_WR_MASK; // RULE_13
            if (lane_allow(status_q) != 4'hf) begin
                rd_val  = {16'h0000, rd_val[15:0]}; // RULE_03
                rd_resp = RESP_SLVERR;
            end
        end else if (s_axi_araddr_i == CPU_CTRL_OFS) begin
            rd_val = cpu_ctrl_q;
        end else if (s_axi_araddr_i == FIRST_CONFIG_REG_OFS) begin
            rd_val = {19'h0, ARCH_REV, 10'h000}; // RULE_08
        end else if (s_axi_araddr_i == COUNT_OFS) begin
            rd_val = count_q;
        end else if (s_axi_araddr_i == COMPARE_OFS) begin
            rd_val = compare_q;
        end else if (s_axi_araddr_i == SECURE_STAT_OFS) begin
            rd_val = secure_stat_q;
        end else begin
            rd_val = regs_q[s_axi_araddr_i[5:2]];
        end
    end

    assign s_axi_arready_o = !rvalid_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_rdata_o   = rdata_q;
    assign s_axi_rresp_o   = rresp_q;
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (s_axi_arvalid_i && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_val;
            rresp_q  <= rd_resp;
        end else if (s_axi_rready_i) begin
            rvalid_q <= 1'b0;
        end
    end

    // per-level interrupt gating, overridden by the global mask
    for (genvar l = 0; l < 4; l++) begin : g_lvl
        always_ff @(posedge ref_clk_i) begin
            if (!reset_n_i)
                irq_en_q[l] <= 1'b0;
            else
                irq_en_q[l] <= irq_req_i[l] && !status_q[LVL_MASK_LSB + l] && !status_q[GLOBAL_MASK_BIT]; // RULE_11
        end
    end

    assign irq_enabled_o   = irq_en_q;
    assign status_word_o   = status_q;
    assign compare_match_o = match_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    chk_global_mask_blocks: assert property ($past(status_q[GLOBAL_MASK_BIT]) |-> irq_enabled_o == 4'h0) // RULE_11
        else $error("interrupt enabled under global mask");
    chk_secure_old_rev: assert property (!IS_REV3 |-> !status_q[SECURE_BIT]) // RULE_05
        else $error("secure flag set before revision 3");
    chk_reserved_zero: assert property ((status_q & ~STATUS_WR_MASK) == 32'h0) // RULE_13
        else $error("reserved status bit set");
    chk_app_upper_held: assert property (status_wr && status_q[MODE_LSB +: 3] == MODE_APP
                                         |=> $stable(status_q[31:16])) // RULE_03
        else $error("upper half changed from application mode");
    chk_app_read_zero: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == STATUS_OFS
                                        && status_q[MODE_LSB +: 3] == MODE_APP
                                        |=> s_axi_rdata_o[31:16] == 16'h0 && s_axi_rresp_o == RESP_SLVERR) // RULE_03
        else $error("upper half visible in application mode");
    chk_config_rev: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == FIRST_CONFIG_REG_OFS
                                     |=> s_axi_rdata_o[REV_LSB +: 3] == ARCH_REV) // RULE_08
        else $error("revision field wrong");
    chk_autoclear: assert property (cmp_hit && !count_wr && !cpu_ctrl_q[NO_AUTO_CLEAR_BIT]
                                    |=> count_q == 32'h0) // RULE_07
        else $error("counter not cleared on match");
    chk_no_autoclear: assert property (cmp_hit && !count_wr && cpu_ctrl_q[NO_AUTO_CLEAR_BIT]
                                       |=> count_q == $past(count_q) + 32'h1) // RULE_07
        else $error("counter cleared despite no_compare_auto_clear");
    chk_secure_absent: assert property (!IS_REV3 && s_axi_arvalid_i && s_axi_arready_o
                                        && s_axi_araddr_i == SECURE_STAT_OFS
                                        |=> s_axi_rresp_o == RESP_DECERR) // RULE_09
        else $error("secure register present before revision 3");
    chk_write_answer: assert property (do_write |=> s_axi_bvalid_o)
        else $error("write not answered");

    cov_status_write: cover property (status_wr ##1 s_axi_bvalid_o && s_axi_bready_i);
    cov_app_refused: cover property (status_wr && upper_refused);
    cov_match: cover property (cmp_hit);
    cov_irq: cover property (|irq_enabled_o);
endmodule

//--- dv/cpu_status_and_mode_state_tb.sv
// random and corner-case testbench for the status word and system registers
// assumes cpu_status_pkg and cpu_status_regs compiled first; two revisions share one bus
`timescale 1ns/1ps
module cpu_status_and_mode_state_tb import cpu_status_pkg::*;;
    localparam logic [31:0] MASK3 = 32'h8dff_403f;
    localparam logic [31:0] MASK2 = 32'h0dff_403f;
    logic        ref_clk_i       = 1'b0;
    logic        reset_n_i       = 1'b0;
    logic [11:0] s_axi_awaddr_i  = 12'h000;
    logic        s_axi_awvalid_i = 1'b0;
    logic [31:0] s_axi_wdata_i   = 32'h0;
    logic [3:0]  s_axi_wstrb_i   = 4'hf;
    logic        s_axi_wvalid_i  = 1'b0;
    logic        s_axi_bready_i  = 1'b0;
    logic [11:0] s_axi_araddr_i  = 12'h000;
    logic        s_axi_arvalid_i = 1'b0;
    logic        s_axi_rready_i  = 1'b0;
    logic [3:0]  irq_req_i       = 4'h0;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, compare_match_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, bresp2, rresp2, brsp, brsp2, rrsp, rrsp2;
    logic [31:0] s_axi_rdata_o, rdata2, status_word_o, sw2, rdat, rdat2, d, e, c;
    logic [3:0]  irq_enabled_o, r;
    logic [31:0] rf [16];
    integer      seed, n_errors, comparisons, cyc, n;

    cpu_status_regs #(.ARCH_REV(3'h3), .SECURE_RESET(1'b1)) cpu_status_regs_inst (
        .ref_clk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
        .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
        .s_axi_rready_i, .irq_req_i, .irq_enabled_o, .status_word_o, .compare_match_o);
    // older revision: secure flag must stay zero even with a reset choice of one
    cpu_status_regs #(.ARCH_REV(3'h2), .SECURE_RESET(1'b1)) cpu_status_regs_inst2 (
        .ref_clk_i, .reset_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o(), .s_axi_wdata_i,
        .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o(), .s_axi_bresp_o(bresp2), .s_axi_bvalid_o(),
        .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o(), .s_axi_rdata_o(rdata2),
        .s_axi_rresp_o(rresp2), .s_axi_rvalid_o(), .s_axi_rready_i, .irq_req_i, .irq_enabled_o(),
        .status_word_o(sw2), .compare_match_o());

    always #12.5 ref_clk_i = ~ref_clk_i;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // writable status bits by revision; reserved bits and, before revision 3, the secure flag read zero
    function automatic logic [31:0] status_exp(input logic [31:0] v, input logic rev3);
        status_exp = v & (rev3 ? MASK3 : MASK2);
    endfunction

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_errors++;
            final_report;
        end
    end

    task automatic do_reset;
        reset_n_i <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        @(posedge ref_clk_i);
    endtask

    // ready is held from the request on; the trailing edge keeps two assignments out of one step
    task automatic wr(input logic [11:0] a, input logic [31:0] dv, input logic [3:0] s);
        s_axi_awaddr_i  <= a;
        s_axi_wdata_i   <= dv;
        s_axi_wstrb_i   <= s;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i  <= 1'b1;
        s_axi_bready_i  <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (s_axi_bvalid_o !== 1'b1);
        brsp  = s_axi_bresp_o;
        brsp2 = bresp2;
        s_axi_bready_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic rd(input logic [11:0] a);
        s_axi_araddr_i  <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i  <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (s_axi_rvalid_o !== 1'b1);
        rdat  = s_axi_rdata_o;
        rrsp  = s_axi_rresp_o;
        rdat2 = rdata2;
        rrsp2 = rresp2;
        s_axi_rready_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    initial begin
        seed = 34737;
        n_errors = 0;
        comparisons = 0;
        cyc = 0;
        do_reset;
        rd(STATUS_OFS);
        chk("reset status", rdat, 32'h8061_0000);
        chk("reset status rev2", rdat2, 32'h0061_0000);
        rd(FIRST_CONFIG_REG_OFS);
        chk("revision", rdat[12:10], 3'h3);
        chk("revision rev2", rdat2[12:10], 3'h2);
        wr(FIRST_CONFIG_REG_OFS, 32'hffff_ffff, 4'hf);
        rd(FIRST_CONFIG_REG_OFS);
        chk("config read-only", rdat[12:10], 3'h3);
        $display("done: reset and configuration");
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            d[24:22] = 3'(i % 7 + 1);
            wr(STATUS_OFS, d, 4'hf);
            rd(STATUS_OFS);
            chk("status", rdat, status_exp(d, 1'b1));
            chk("status port", status_word_o, status_exp(d, 1'b1));
            chk("status rev2", rdat2, status_exp(d, 1'b0));
        end
        $display("done: status fields");
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 32'h0041_0000 : $random(seed);
            d[24:22] = 3'h1;
            r = (i == 0) ? 4'hf : 4'($random(seed));
            irq_req_i <= r;
            wr(STATUS_OFS, d, 4'hf);
            repeat (3) @(posedge ref_clk_i);
            chk("irq enable", irq_enabled_o, r & ~d[20:17] & ~{4{d[16]}});
        end
        $display("done: interrupt masking");
        for (int i = 0; i < 16; i++) begin
            rf[i] = $random(seed);
            wr(REGFILE_OFS + 12'(4 * i), rf[i], 4'hf);
        end
        for (int i = 0; i < 16; i++) begin
            rd(REGFILE_OFS + 12'(4 * i));
            chk("register file", rdat, rf[i]);
        end
        wr(12'h004, $random(seed), 4'hf);
        chk("unmapped write", brsp, RESP_DECERR);
        rd(12'h004);
        chk("unmapped read", rdat, 32'h0);
        e = $random(seed);
        wr(SECURE_STAT_OFS, e, 4'hf);
        chk("secure write rev3", brsp, RESP_OKAY);
        chk("secure write rev2", brsp2, RESP_DECERR);
        rd(SECURE_STAT_OFS);
        chk("secure regs rev3", rrsp, RESP_OKAY);
        chk("secure regs rev2", rrsp2, RESP_DECERR);
        chk("secure data rev3", rdat, e);
        chk("secure data rev2", rdat2, 32'h0);
        $display("done: register file and map");
        for (int k = 0; k < 2; k++) begin
            wr(CPU_CTRL_OFS, 32'(k), 4'hf);
            rd(COUNT_OFS);
            c = rdat;
            wr(COMPARE_OFS, c + 32'd60, 4'hf);
            n = 0;
            while (compare_match_o !== 1'b1 && n < 200) begin
                @(posedge ref_clk_i);
                n++;
            end
            chk("compare match", compare_match_o, 1'b1);
            repeat (20) @(posedge ref_clk_i);
            rd(COUNT_OFS);
            chk("count after match", (k == 0) ? rdat < c : rdat > c + 32'd60, 1'b1);
            chk("count rev2 clears", rdat2 < c, 1'b1);
        end
        $display("done: compare auto-clear");
        d = $random(seed);
        d[24:22] = MODE_APP;
        wr(STATUS_OFS, d, 4'hf);
        chk("enter application", brsp, RESP_OKAY);
        e = $random(seed);
        wr(STATUS_OFS, e, 4'hf);
        chk("upper write refused", brsp, RESP_SLVERR);
        chk("upper kept", status_word_o[31:16], d[31:16] & MASK3[31:16]);
        rd(STATUS_OFS);
        chk("upper read refused", rrsp, RESP_SLVERR);
        chk("lower in application", rdat, {16'h0, e[15:0] & MASK3[15:0]});
        $display("done: application mode");
        do_reset;
        rd(STATUS_OFS);
        chk("second reset", rdat, 32'h8061_0000);
        $display("done: second reset");
        final_report;
    end
endmodule
